// *** src/prg_top.sv ***
// Test pattern generator and detector for one framer channel group
// Function
// - Pseudo-random generator is a 32-bit register fed by one XOR of two stages
// - Repetitive select makes the register recirculate over the programmed length
// - Repetitive mode sends the insertion words continuously, phase not guaranteed
// - Repetitive detector captures N bits, checks 48 bits, retries, then counts
// - Detector locks to any repeat of that length, not the insertion words
// - With readout select 00 the result holds the 32 bits before the strobe
// - Counters latch on detector write, global update write or periodic update
// - Each latch presents error count, received bit count and last 32 bits
// - Egress test channels with per-channel enable form one pattern stream
// - Detector syncs to ingress test channels and then counts bit errors
// - Unframed generate fills every bit; unframed detect searches every bit
// - Receive-side generate replaces ingress data; detector then watches egress
// - Seven-bit options skip each channel's least significant bit
// - With the elastic store in path the detector reads its output
// - An elastic store slip forces the detector to lose lock
// - An all-ones trouble code locks the repetitive detector
`timescale 1ns/10ps
module prg_top #(
    parameter int AUTO_LATCH_CYCLES = prg_pkg::AUTO_LATCH_CYCLES_DEF
) (
    input logic core_clk,
    input logic reset_n,
    input logic repetitive_select,
    input prg_pkg::prg_len_t pattern_length,
    input prg_pkg::prg_len_t feedback_tap,
    input prg_pkg::prg_byte_t insertion_word_one,
    input prg_pkg::prg_byte_t insertion_word_two,
    input prg_pkg::prg_byte_t insertion_word_three,
    input prg_pkg::prg_byte_t insertion_word_four,
    input logic insertion_write,
    input logic tx_invert,
    input logic rx_invert,
    input prg_pkg::prg_rsel_t detector_readout_select,
    input logic unframed_generate,
    input logic unframed_detect,
    input logic receive_side_generate,
    input logic seven_bit_generate,
    input logic seven_bit_detect,
    input logic per_channel_enable,
    input logic elastic_store_enable,
    input logic periodic_auto_latch,
    input logic detector_reg_write,
    input logic global_update_write,
    input logic elastic_store_slip,
    input logic egress_bit_valid,
    input logic egress_data,
    input logic egress_test_sel,
    input logic egress_framing_bit,
    input logic egress_lsb,
    output logic egress_in_ready,
    output logic egress_out_valid,
    output logic egress_out_data,
    input logic egress_out_ready,
    input logic ingress_bit_valid,
    input logic receive_line_data,
    input logic elastic_store_data,
    input logic ingress_test_sel,
    input logic ingress_framing_bit,
    input logic ingress_lsb,
    output logic receive_out_valid,
    output logic receive_out_data,
    output prg_pkg::prg_word_t result_word,
    output logic detector_locked
);
    import prg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Slot selection and generator
    prg_bit_if buf_in ();
    prg_bit_if buf_out ();
    prg_word_t gen_state;
    logic gen_bit;
    logic eg_acc;
    logic eg_gslot;
    logic eg_dslot;
    logic eg_ins;
    logic rx_gslot;
    logic rx_ins;
    logic ing_slot;
    logic ing_data;
    logic gen_adv;
    logic det_valid;
    logic det_bit;

    always_comb begin
        eg_acc = egress_bit_valid & egress_in_ready;
        eg_gslot = unframed_generate | (per_channel_enable & egress_test_sel
            & ~egress_framing_bit & ~(seven_bit_generate & egress_lsb));
        eg_dslot = unframed_detect | (per_channel_enable & egress_test_sel
            & ~egress_framing_bit & ~(seven_bit_detect & egress_lsb));
        rx_gslot = unframed_generate | (per_channel_enable & ingress_test_sel
            & ~ingress_framing_bit & ~(seven_bit_generate & ingress_lsb));
        ing_slot = unframed_detect | (per_channel_enable & ingress_test_sel
            & ~ingress_framing_bit & ~(seven_bit_detect & ingress_lsb));
        eg_ins = eg_acc & eg_gslot & ~receive_side_generate;
        rx_ins = ingress_bit_valid & rx_gslot & receive_side_generate;
        gen_adv = eg_ins | rx_ins;
        ing_data = elastic_store_enable ? elastic_store_data : receive_line_data;
        if (receive_side_generate) begin
            det_valid = eg_acc & eg_dslot;
            det_bit = egress_data ^ rx_invert;
        end else begin
            det_valid = ingress_bit_valid & ing_slot;
            det_bit = ing_data ^ rx_invert;
        end
        buf_in.valid = egress_bit_valid;
        buf_in.data = eg_ins ? (gen_bit ^ tx_invert) : egress_data;
        buf_out.ready = egress_out_ready;
    end

    prg_gen_sr u_gen (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .advance(gen_adv),
        .load(insertion_write),
        .repetitive(repetitive_select),
        .length(pattern_length),
        .tap(feedback_tap),
        .seed({insertion_word_four, insertion_word_three, insertion_word_two,
            insertion_word_one}),
        .state(gen_state),
        .out_bit(gen_bit)
    );

    prg_buf2 u_buf (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_if(buf_in),
        .out_if(buf_out)
    );

    assign egress_in_ready = buf_in.ready;
    assign egress_out_valid = buf_out.valid;
    assign egress_out_data = buf_out.data;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive path output
    logic rx_valid_q;
    logic rx_valid_d;
    logic rx_data_q;
    logic rx_data_d;

    always_comb begin
        rx_valid_d = ingress_bit_valid;
        rx_data_d = rx_ins ? (gen_bit ^ tx_invert) : ing_data;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_valid_q <= 1'b0;
            rx_data_q <= 1'b0;
        end else begin
            rx_valid_q <= rx_valid_d;
            rx_data_q <= rx_data_d;
        end
    end

    assign receive_out_valid = rx_valid_q;
    assign receive_out_data = rx_data_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Detector synchronisation
    prg_det_state_t state_q;
    prg_det_state_t state_d;
    prg_word_t hist_q;
    prg_word_t hist_d;
    prg_cnt6_t fill_q;
    prg_cnt6_t fill_d;
    prg_cnt6_t match_q;
    prg_cnt6_t match_d;
    prg_cnt6_t win_q;
    prg_cnt6_t win_d;
    prg_cnt6_t werr_q;
    prg_cnt6_t werr_d;
    logic locked_q;
    logic locked_d;
    logic expected;
    logic mismatch;

    always_comb begin
        // Compare with own history only, so in repetitive mode any repeat of the length locks
        expected = repetitive_select ? hist_q[pattern_length]
            : (hist_q[pattern_length] ^ hist_q[feedback_tap]);
        mismatch = det_bit ^ expected;
        state_d = state_q;
        hist_d = hist_q;
        fill_d = fill_q;
        match_d = match_q;
        win_d = win_q;
        werr_d = werr_q;
        if (det_valid) begin
            hist_d = {hist_q[GEN_W-2:0], det_bit};
            case (state_q)
                DET_FILL: begin
                    fill_d = fill_q + 6'h01;
                    if (fill_q == {1'b0, pattern_length}) begin
                        state_d = DET_VERIFY;
                        match_d = 6'h00;
                    end
                end
                DET_VERIFY: begin
                    if (mismatch) begin
                        state_d = DET_FILL;
                        fill_d = 6'h00;
                    end else if (match_q == SYNC_BITS - 6'h01) begin
                        state_d = DET_LOCK;
                        win_d = 6'h00;
                        werr_d = 6'h00;
                    end else begin
                        match_d = match_q + 6'h01;
                    end
                end
                DET_LOCK: begin
                    werr_d = werr_q + {5'h00, mismatch};
                    win_d = win_q + 6'h01;
                    if (win_q == LOSS_WIN_BITS - 6'h01) begin
                        win_d = 6'h00;
                        werr_d = 6'h00;
                        if (werr_q + {5'h00, mismatch} >= LOSS_ERRS) begin
                            state_d = DET_FILL;
                            fill_d = 6'h00;
                        end
                    end
                end
                default: begin
                    state_d = DET_FILL;
                    fill_d = 6'h00;
                end
            endcase
        end
        if (elastic_store_slip) begin
            state_d = DET_FILL;
            fill_d = 6'h00;
        end
        locked_d = (state_d == DET_LOCK);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= DET_FILL;
            hist_q <= GEN_RESET_VALUE;
            fill_q <= 6'h00;
            match_q <= 6'h00;
            win_q <= 6'h00;
            werr_q <= 6'h00;
            locked_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hist_q <= hist_d;
            fill_q <= fill_d;
            match_q <= match_d;
            win_q <= win_d;
            werr_q <= werr_d;
            locked_q <= locked_d;
        end
    end

    assign detector_locked = locked_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Counters, latch and readout
    prg_word_t acc_err_q;
    prg_word_t acc_err_d;
    prg_word_t acc_bits_q;
    prg_word_t acc_bits_d;
    prg_word_t lat_err_q;
    prg_word_t lat_err_d;
    prg_word_t lat_bits_q;
    prg_word_t lat_bits_d;
    prg_word_t snap_q;
    prg_word_t snap_d;
    prg_word_t res_q;
    prg_word_t res_d;
    prg_word_t auto_q;
    prg_word_t auto_d;
    logic auto_fire;
    logic latch;
    prg_word_t err_now;
    prg_word_t bit_now;

    always_comb begin
        auto_fire = periodic_auto_latch & (auto_q == 32'(AUTO_LATCH_CYCLES - 1));
        auto_d = (periodic_auto_latch & ~auto_fire) ? auto_q + 32'h1 : 32'h0;
        latch = detector_reg_write | global_update_write | auto_fire;
        bit_now = {31'h0, det_valid & (state_q == DET_LOCK)};
        err_now = {31'h0, det_valid & (state_q == DET_LOCK) & mismatch};
        acc_err_d = acc_err_q + err_now;
        acc_bits_d = acc_bits_q + bit_now;
        lat_err_d = lat_err_q;
        lat_bits_d = lat_bits_q;
        snap_d = snap_q;
        if (latch) begin
            lat_err_d = acc_err_q + err_now;
            lat_bits_d = acc_bits_q + bit_now;
            snap_d = hist_q;
            acc_err_d = 32'h0;
            acc_bits_d = 32'h0;
        end
        if (detector_readout_select == RSEL_BITS) begin
            res_d = snap_q;
        end else if (detector_readout_select == RSEL_ERRS) begin
            res_d = lat_err_q;
        end else if (detector_readout_select == RSEL_RCVD) begin
            res_d = lat_bits_q;
        end else begin
            res_d = {29'h0, state_q};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_err_q <= 32'h0;
            acc_bits_q <= 32'h0;
            lat_err_q <= 32'h0;
            lat_bits_q <= 32'h0;
            snap_q <= 32'h0;
            res_q <= 32'h0;
            auto_q <= 32'h0;
        end else begin
            acc_err_q <= acc_err_d;
            acc_bits_q <= acc_bits_d;
            lat_err_q <= lat_err_d;
            lat_bits_q <= lat_bits_d;
            snap_q <= snap_d;
            res_q <= res_d;
            auto_q <= auto_d;
        end
    end

    assign result_word = res_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_latch_bits;
        latch && detector_readout_select == RSEL_BITS;
    endsequence
    sequence s_hold_bits;
        detector_readout_select == RSEL_BITS;
    endsequence

    a_prbs_feedback: assert property (
        gen_adv && !repetitive_select && !insertion_write |=>
        gen_state[0] == $past(gen_state[pattern_length] ^ gen_state[feedback_tap]))
        else $error("generator feedback is not the tap XOR");
    a_rep_recirc: assert property (
        gen_adv && repetitive_select && !insertion_write |=>
        gen_state[0] == $past(gen_state[pattern_length]))
        else $error("repetitive register does not recirculate");
    a_lock_after_sync: assert property (
        $rose(detector_locked) |-> $past(state_q) == DET_VERIFY
        && $past(match_q) == SYNC_BITS - 6'h01)
        else $error("lock without the required run of matches");
    a_readout_snap: assert property (
        s_latch_bits ##1 s_hold_bits |=> result_word == $past(hist_q, 2))
        else $error("readout does not hold bits before the strobe");
    a_latch_clears: assert property (
        latch |=> acc_bits_q <= 32'h1 && acc_err_q <= acc_bits_q)
        else $error("latch did not restart the counters");
    a_latch_counts: assert property (
        latch |=> lat_err_q == $past(acc_err_q + err_now)
        && lat_bits_q == $past(acc_bits_q + bit_now))
        else $error("latched counts differ from the accumulated counts");
    a_error_count: assert property (
        state_q == DET_LOCK && det_valid && mismatch && !latch && !elastic_store_slip |=>
        acc_err_q == $past(acc_err_q) + 32'h1)
        else $error("bit error not counted");
    a_rx_replace: assert property (
        receive_side_generate && ingress_bit_valid && rx_gslot |=>
        receive_out_valid && receive_out_data == $past(gen_bit ^ tx_invert))
        else $error("receive data not replaced by the pattern");
    a_seven_bit_skip: assert property (
        seven_bit_generate && !unframed_generate && egress_lsb && !insertion_write
        && !(ingress_bit_valid && rx_ins) |=> $stable(gen_state))
        else $error("generator advanced on a skipped bit");
    a_slip_unlock: assert property (
        elastic_store_slip |=> !detector_locked ##1 state_q != DET_LOCK)
        else $error("slip did not drop lock");
endmodule : prg_top

// *** src/prg_pkg.sv ***
// Shared constants and types for the pattern generator and detector
package prg_pkg;
    localparam int GEN_W = 32;
    localparam int LEN_W = 5;
    typedef logic [GEN_W-1:0] prg_word_t;
    typedef logic [LEN_W-1:0] prg_len_t;
    typedef logic [7:0] prg_byte_t;
    typedef logic [1:0] prg_rsel_t;
    typedef logic [5:0] prg_cnt6_t;
    // Generator shift register value after reset
    localparam prg_word_t GEN_RESET_VALUE = 32'hFFFFFFFF;
    // Error-free bit periods needed before lock
    localparam prg_cnt6_t SYNC_BITS = 6'h30;
    // Loss-of-lock window and error threshold
    localparam prg_cnt6_t LOSS_WIN_BITS = 6'h30;
    localparam prg_cnt6_t LOSS_ERRS = 6'h06;
    // Readout select codes
    localparam prg_rsel_t RSEL_BITS = 2'h0;
    localparam prg_rsel_t RSEL_ERRS = 2'h1;
    localparam prg_rsel_t RSEL_RCVD = 2'h2;
    localparam prg_rsel_t RSEL_STAT = 2'h3;
    // Periodic latch interval
    localparam int CLK_PERIOD_NS = 4;
    localparam int AUTO_LATCH_PERIOD_MS = 1000;
    localparam int AUTO_LATCH_CYCLES_DEF = AUTO_LATCH_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    // Two-entry buffer occupancy after reset and when full
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] BUF_FULL = 2'h2;
    typedef enum logic [2:0] {
        DET_FILL = 3'h1,
        DET_VERIFY = 3'h2,
        DET_LOCK = 3'h4
    } prg_det_state_t;
endpackage : prg_pkg

// *** src/prg_bit_if.sv ***
// Valid and ready carrier for one serial bit
`timescale 1ns/10ps
interface prg_bit_if;
    logic valid;
    logic ready;
    logic data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : prg_bit_if

// *** src/prg_buf2.sv ***
// Two-entry bit buffer with registered valid, ready and head
`timescale 1ns/10ps
module prg_buf2 (
    input logic core_clk,
    input logic reset_n,
    prg_bit_if.snk in_if,
    prg_bit_if.src out_if
);
    import prg_pkg::*;
    logic [1:0] mem_q;
    logic [1:0] mem_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic valid_q;
    logic valid_d;
    logic ready_q;
    logic ready_d;
    logic push;
    logic pop;
    logic [1:0] wr_idx;

    always_comb begin
        push = in_if.valid & ready_q;
        pop = valid_q & out_if.ready;
        mem_d = mem_q;
        cnt_d = cnt_q;
        wr_idx = cnt_q;
        if (pop) begin
            mem_d[0] = mem_q[1];
            cnt_d = cnt_q - 2'h1;
            wr_idx = cnt_q - 2'h1;
        end
        if (push) begin
            mem_d[wr_idx[0]] = in_if.data;
            cnt_d = cnt_d + 2'h1;
        end
        valid_d = (cnt_d != BUF_EMPTY);
        ready_d = (cnt_d != BUF_FULL);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_q <= 2'h0;
            cnt_q <= BUF_EMPTY;
            valid_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            mem_q <= mem_d;
            cnt_q <= cnt_d;
            valid_q <= valid_d;
            ready_q <= ready_d;
        end
    end

    assign in_if.ready = ready_q;
    assign out_if.valid = valid_q;
    assign out_if.data = mem_q[0];
endmodule : prg_buf2

// *** src/prg_gen_sr.sv ***
// Generator shift register with XOR feedback or recirculation
`timescale 1ns/10ps
module prg_gen_sr (
    input logic core_clk,
    input logic reset_n,
    input logic advance,
    input logic load,
    input logic repetitive,
    input prg_pkg::prg_len_t length,
    input prg_pkg::prg_len_t tap,
    input prg_pkg::prg_word_t seed,
    output prg_pkg::prg_word_t state,
    output logic out_bit
);
    import prg_pkg::*;
    prg_word_t sr_q;
    prg_word_t sr_d;
    logic fb;

    always_comb begin
        fb = repetitive ? sr_q[length] : (sr_q[length] ^ sr_q[tap]);
        sr_d = sr_q;
        if (load) begin
            sr_d = seed;
        end else if (advance) begin
            sr_d = {sr_q[GEN_W-2:0], fb};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sr_q <= GEN_RESET_VALUE;
        end else begin
            sr_q <= sr_d;
        end
    end

    assign state = sr_q;
    assign out_bit = sr_q[length];
endmodule : prg_gen_sr

// *** tb/prg_far_loop.sv ***
// Far-end line model that loops the egress test stream back as ingress slots
`timescale 1ns/10ps
module prg_far_loop (
    input logic core_clk,
    input logic reset_n,
    input logic run,
    input logic inject,
    input logic out_valid,
    input logic out_data,
    output logic out_ready,
    output logic in_valid,
    output logic in_data
);
    logic pend_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Loopback with random stalls and single-bit corruption on request
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_ready <= 1'b0;
            in_valid <= 1'b0;
            in_data <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            out_ready <= run && ($urandom_range(3) != 0);
            in_valid <= out_valid && out_ready;
            if (out_valid && out_ready) begin
                in_data <= out_data ^ (pend_q | inject);
                pend_q <= 1'b0;
            end else begin
                // Idle line shows no stale value
                in_data <= ~in_data;
                pend_q <= pend_q | inject;
            end
        end
    end
endmodule : prg_far_loop

// *** tb/tb.sv ***
// Self-checking bench for the pattern generator and detector
`timescale 1ns/10ps
module tb;
    import prg_pkg::*;
    localparam int AUTO_N = 64;
    localparam logic [2:0] CFG_REP = 3'h1;
    localparam logic [2:0] CFG_INV = 3'h4;
    localparam prg_len_t CFG_LEN [3] = '{5'h07, 5'h06, 5'h0E};
    localparam prg_len_t CFG_TAP [3] = '{5'h00, 5'h00, 5'h0D};
    localparam prg_byte_t CFG_W1 [3] = '{8'h01, 8'hFF, 8'hFF};
    logic core_clk = 1'b0, reset_n = 1'b0, repetitive_select = 1'b0, insertion_write = 1'b0;
    prg_len_t pattern_length = 5'h00, feedback_tap = 5'h00;
    prg_byte_t insertion_word_one = 8'hFF, insertion_word_two = 8'hFF;
    prg_byte_t insertion_word_three = 8'hFF, insertion_word_four = 8'hFF;
    prg_rsel_t detector_readout_select = RSEL_BITS;
    logic tx_invert = 1'b0, rx_invert = 1'b0, unframed_generate = 1'b1, unframed_detect = 1'b1;
    logic receive_side_generate = 1'b0, seven_bit_generate = 1'b0, seven_bit_detect = 1'b0;
    logic per_channel_enable = 1'b1, elastic_store_enable = 1'b0, periodic_auto_latch = 1'b0;
    logic detector_reg_write = 1'b0, global_update_write = 1'b0, elastic_store_slip = 1'b0;
    logic egress_bit_valid = 1'b0, egress_data = 1'b0, egress_test_sel = 1'b1, egress_lsb = 1'b0;
    logic egress_framing_bit = 1'b0, ingress_framing_bit = 1'b0, ingress_lsb = 1'b0;
    logic elastic_store_data = 1'b1, ingress_test_sel = 1'b1, ingress_bit_valid, receive_line_data;
    logic egress_in_ready, egress_out_valid, egress_out_data, egress_out_ready;
    logic receive_out_valid, receive_out_data, detector_locked;
    logic run = 1'b0, inject = 1'b0, took = 1'b0, own_pat = 1'b0, es_ones = 1'b0, probe = 1'b0;
    logic [1:0] probe_kind = 2'h0;
    logic [1:0] ph = 2'h0;
    prg_word_t result_word, exp_w, got_w;
    prg_word_t hist = 32'h0;
    prg_word_t exp_q[$];
    int n_fail = 0, comparisons = 0, n_bits = 0, cycles = 0;
    always #2 core_clk = ~core_clk;
    prg_top #(.AUTO_LATCH_CYCLES(AUTO_N)) i_prg_top (.core_clk, .reset_n, .repetitive_select,
        .pattern_length, .feedback_tap, .insertion_word_one, .insertion_word_two,
        .insertion_word_three, .insertion_word_four, .insertion_write, .tx_invert, .rx_invert,
        .detector_readout_select, .unframed_generate, .unframed_detect, .receive_side_generate,
        .seven_bit_generate, .seven_bit_detect, .per_channel_enable, .elastic_store_enable,
        .periodic_auto_latch, .detector_reg_write, .global_update_write, .elastic_store_slip,
        .egress_bit_valid, .egress_data, .egress_test_sel, .egress_framing_bit, .egress_lsb,
        .egress_in_ready, .egress_out_valid, .egress_out_data, .egress_out_ready,
        .ingress_bit_valid, .receive_line_data, .elastic_store_data, .ingress_test_sel,
        .ingress_framing_bit, .ingress_lsb, .receive_out_valid, .receive_out_data,
        .result_word, .detector_locked);
    prg_far_loop i_prg_far_loop (.core_clk, .reset_n, .run, .inject,
        .out_valid(egress_out_valid), .out_data(egress_out_data), .out_ready(egress_out_ready),
        .in_valid(ingress_bit_valid), .in_data(receive_line_data));
    ////////////////////////////////////////////////////////////////////////////////
    // Tracking, timeout and result monitor
    always @(posedge core_clk) begin
        took <= egress_bit_valid && egress_in_ready;
        ph <= ph + {1'b0, egress_bit_valid && egress_in_ready};
        if (ingress_bit_valid) begin
            hist <= {hist[30:0], receive_line_data};
            n_bits <= n_bits + 1;
        end
        cycles <= cycles + 1;
        if (probe) begin
            exp_w = exp_q.pop_front();
            got_w = (probe_kind == 2'h0) ? result_word : {30'h0, (probe_kind == 2'h3) ?
                {receive_out_valid, receive_out_data} : {1'b0, (probe_kind == 2'h1) ?
                detector_locked : egress_in_ready}};
            comparisons++;
            if (got_w !== exp_w) begin
                n_fail++;
                $display("unexpected at %0t: got %h expected %h", $time, got_w, exp_w);
            end
        end
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end
    always @(negedge core_clk) begin
        if (took) begin
            egress_data <= own_pat ? (ph == 2'h0) : 1'($urandom);
            egress_lsb <= 1'($urandom);
            egress_framing_bit <= 1'($urandom);
            egress_test_sel <= 1'($urandom);
        end
        ingress_lsb <= 1'($urandom);
        ingress_test_sel <= 1'($urandom);
        elastic_store_data <= es_ones | 1'($urandom);
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic expect_v(input logic [1:0] k, input prg_word_t v);
        exp_q.push_back(v);
        probe_kind = k;
        probe = 1'b1;
        @(posedge core_clk);
        probe <= 1'b0;
        @(negedge core_clk);
    endtask : expect_v
    task automatic setup(input logic r, input prg_len_t l, input prg_len_t t,
        input prg_byte_t w, input logic inv);
        repetitive_select = r;
        pattern_length = l;
        feedback_tap = t;
        insertion_word_one = w;
        tx_invert = inv;
        rx_invert = inv;
        insertion_write = 1'b1;
        elastic_store_slip = 1'b1;
        @(negedge core_clk);
        insertion_write = 1'b0;
        elastic_store_slip = 1'b0;
        run = 1'b1;
        for (int i = 0; i < 3000 && detector_locked !== 1'b1; i++) @(negedge core_clk);
    endtask : setup
    task automatic stop_latch(input logic g);
        run = 1'b0;
        repeat (20) @(negedge core_clk);
        global_update_write = g;
        detector_reg_write = !g;
        @(negedge core_clk);
        global_update_write = 1'b0;
        detector_reg_write = 1'b0;
    endtask : stop_latch
    task automatic readout(input prg_rsel_t s, input prg_word_t v);
        detector_readout_select = s;
        repeat (3) @(negedge core_clk);
        expect_v(2'h0, v);
    endtask : readout
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(83511));
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        egress_bit_valid = 1'b1;
        expect_v(2'h1, 32'h0);
        expect_v(2'h0, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            setup(CFG_REP[k], CFG_LEN[k], CFG_TAP[k], CFG_W1[k], CFG_INV[k]);
            expect_v(2'h1, 32'h1);
            stop_latch(1'b0);
            if (!CFG_INV[k]) readout(RSEL_BITS, hist);
            readout(RSEL_ERRS, 32'h0);
            $display("test pattern %0d done", k);
        end
        setup(1'b1, 5'h07, 5'h00, 8'h01, 1'b0);
        stop_latch(1'b0);
        expect_v(2'h2, 32'h0);
        n_bits = 0;
        run = 1'b1;
        repeat (2) begin
            repeat (100) @(negedge core_clk);
            inject = 1'b1;
            @(negedge core_clk);
            inject = 1'b0;
        end
        repeat (100) @(negedge core_clk);
        stop_latch(1'b1);
        readout(RSEL_ERRS, 32'h4);
        readout(RSEL_RCVD, 32'(n_bits));
        periodic_auto_latch = 1'b1;
        repeat (3 * AUTO_N) @(negedge core_clk);
        readout(RSEL_RCVD, 32'h0);
        periodic_auto_latch = 1'b0;
        $display("test counters done");
        unframed_generate = 1'b0;
        elastic_store_enable = 1'b1;
        es_ones = 1'b1;
        seven_bit_generate = 1'b1;
        setup(1'b1, 5'h07, 5'h00, 8'h01, 1'b0);
        expect_v(2'h1, 32'h1);
        run = 1'b0;
        elastic_store_slip = 1'b1;
        @(negedge core_clk);
        elastic_store_slip = 1'b0;
        repeat (2) @(negedge core_clk);
        expect_v(2'h1, 32'h0);
        expect_v(2'h3, 32'h1);
        $display("test elastic store done");
        elastic_store_enable = 1'b0;
        es_ones = 1'b0;
        own_pat = 1'b1;
        receive_side_generate = 1'b1;
        setup(1'b1, 5'h03, 5'h00, 8'hFF, 1'b0);
        expect_v(2'h1, 32'h1);
        $display("test receive side done");
        final_report();
    end
endmodule : tb
